/* File: common/uedf_cfg.svh */
// offsets, field positions and reset values of the descriptor block
// assumes a 32-bit AXI4-Lite slave, one byte register per aligned word
`ifndef UEDF_CFG_SVH
`define UEDF_CFG_SVH
// ==========================================================
// address map
`define UEDF_ADDR_IRQ_STAT 3'h0
`define UEDF_ADDR_IRQ_MASK 3'h1
`define UEDF_IDX_OSCNT 3'h0
`define UEDF_IDX_OSIZE 3'h1
`define UEDF_IDX_CNF 3'h2
`define UEDF_IDX_BASE 3'h3
`define UEDF_IDX_PCNT 3'h4
// ==========================================================
// field positions
`define UEDF_NAK 7
`define UEDF_BME 7
`define UEDF_ISO 6
`define UEDF_TGL 5
`define UEDF_DOUBLE_BUFFER_ENABLE 4
`define UEDF_STALL 3
`define UEDF_IE 2
// ==========================================================
// write masks, reset values and response codes
`define UEDF_SIZE_WMASK 8'h7F
`define UEDF_CNF_WMASK 8'hFC
`define UEDF_RST_OSCNT 8'h00
`define UEDF_RST_OSIZE 8'h00
`define UEDF_RST_CNF 8'h00
`define UEDF_RST_BASE 8'h00
`define UEDF_RST_PCNT 8'h80
`define UEDF_RESP_OK 2'h0
`define UEDF_RESP_ERR 2'h2
`endif

/* File: common/uedf_pkg.sv */
// types shared by the descriptor block and the buffer manager model
// assumes nothing beyond the cfg header
package uedf_pkg;
    // ======================================================
    // buffer manager answers
    typedef enum logic [2:0] {
        rsp_nak,
        rsp_stall,
        rsp_primary,
        rsp_second,
        rsp_off,
        rsp_ack
    } uedf_rsp_t;
endpackage : uedf_pkg

/* File: rtl/uedf_ep.sv */
// descriptor fields of one non-control endpoint
// assumes single-cycle event pulses from the same clock domain
`timescale 1ns/1ns
`include "uedf_cfg.svh"
module uedf_ep (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register access
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_idx,
    output logic [7:0] rd_data,
    // buffer manager events
    input wire logic stall_clr,
    input wire logic stall_set,
    input wire logic in_done,
    input wire logic in_done_primary,
    input wire logic out_done,
    input wire logic [6:0] out_cnt,
    // descriptor fields
    output logic [7:0] out_scnt_q,
    output logic [7:0] out_size_q,
    output logic [7:0] in_cnf_q,
    output logic [7:0] in_base_q,
    output logic [7:0] in_pcnt_q
);
    // ======================================================
    // next values
    wire we_oscnt = wr_en && (wr_idx == `UEDF_IDX_OSCNT);
    wire we_osize = wr_en && (wr_idx == `UEDF_IDX_OSIZE);
    wire we_cnf = wr_en && (wr_idx == `UEDF_IDX_CNF);
    wire we_base = wr_en && (wr_idx == `UEDF_IDX_BASE);
    wire we_pcnt = wr_en && (wr_idx == `UEDF_IDX_PCNT);
    wire [7:0] cnf_w = we_cnf ? (wr_data & `UEDF_CNF_WMASK) : in_cnf_q;
    // firmware set of stall beats the automatic clear
    wire stall_d = stall_set | (we_cnf ? wr_data[`UEDF_STALL] :
        (in_cnf_q[`UEDF_STALL] & ~stall_clr)); // RULE5 RULE6
    wire tgl_d = in_done ? ~in_cnf_q[`UEDF_TGL] : cnf_w[`UEDF_TGL]; // RULE8
    wire [7:0] cnf_d = {cnf_w[7:6], tgl_d, cnf_w[4], stall_d,
        cnf_w[2:0]};
    // received packet marks the buffer full, hardware wins
    wire [7:0] oscnt_d = out_done ? {1'b1, out_cnt} :
        (we_oscnt ? wr_data : out_scnt_q); // RULE1 RULE2
    wire [7:0] osize_d = we_osize ? (wr_data & `UEDF_SIZE_WMASK) :
        out_size_q; // RULE3
    wire [7:0] base_d = we_base ? wr_data : in_base_q; // RULE12 RULE13
    wire nak_d = in_done_primary |
        (we_pcnt ? wr_data[`UEDF_NAK] : in_pcnt_q[`UEDF_NAK]); // RULE16
    wire [6:0] pc_d = we_pcnt ? wr_data[6:0] : in_pcnt_q[6:0]; // RULE14
    // ======================================================
    // read selection
    assign rd_data = (rd_idx == `UEDF_IDX_OSCNT) ? out_scnt_q :
        (rd_idx == `UEDF_IDX_OSIZE) ? out_size_q :
        (rd_idx == `UEDF_IDX_CNF) ? in_cnf_q :
        (rd_idx == `UEDF_IDX_BASE) ? in_base_q : in_pcnt_q;
    // ======================================================
    // storage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_scnt_q <= `UEDF_RST_OSCNT;
            out_size_q <= `UEDF_RST_OSIZE;
            in_cnf_q <= `UEDF_RST_CNF;
            in_base_q <= `UEDF_RST_BASE;
            in_pcnt_q <= `UEDF_RST_PCNT;
        end
        else
        begin
            out_scnt_q <= oscnt_d;
            out_size_q <= osize_d;
            in_cnf_q <= cnf_d;
            in_base_q <= base_d;
            in_pcnt_q <= {nak_d, pc_d};
        end
    end
endmodule : uedf_ep

/* File: rtl/uedf_top.sv */
// descriptor fields of endpoints 1 to 3 behind an AXI4-Lite slave
// assumes the buffer manager runs on aclk and pulses its events
//
// Function
// RULE1 - output secondary count is seven bits, 0 to 64 bytes
// RULE2 - output secondary flag set means full; host OUT gets NAK
// RULE3 - one seven-bit output buffer size; bit 7 reserved, reads zero
// RULE4 - interrupt enable bit raises completion interrupt per transaction; code raises it on IN completions only, never on OUT
// RULE5 - stall bit set by buffer manager, set or cleared by firmware
// RULE6 - firmware stall gives STALL handshake, then bit clears itself
// RULE7 - double buffer bit lets toggle pick primary or secondary
// RULE8 - toggle bit tracks DATA0/DATA1 sequence state
// RULE9 - firmware keeps isochronous bit at zero
// RULE10 - enable bit gates buffer manager use of the endpoint
// RULE11 - base register is address 10:3, low three bits zero
// RULE12 - base gives transaction start address, never changed by hardware
// RULE13 - firmware programs base before use; hardware never writes it
// RULE14 - input primary count is seven bits, 0 to 64 bytes
// RULE15 - input primary flag set means empty; host IN gets NAK
// RULE16 - IN completion sets NAK, flips toggle, raises enabled interrupt; code sets NAK on primary-buffer completions only
`timescale 1ns/1ns
`include "uedf_cfg.svh"
module uedf_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // host IN requests
    input wire logic bm_in_req,
    input wire logic [1:0] bm_in_ep,
    output logic bm_in_valid_q,
    output uedf_pkg::uedf_rsp_t bm_in_rsp_q,
    output logic [10:0] bm_in_addr_q,
    output logic [6:0] bm_in_cnt_q,
    // host IN completion and stall
    input wire logic bm_in_done,
    input wire logic [1:0] bm_in_done_ep,
    input wire logic bm_in_done_second,
    input wire logic bm_stall_set,
    input wire logic [1:0] bm_stall_ep,
    // host OUT requests
    input wire logic bm_out_req,
    input wire logic [1:0] bm_out_ep,
    output logic bm_out_valid_q,
    output uedf_pkg::uedf_rsp_t bm_out_rsp_q,
    output logic [6:0] bm_out_size_q,
    // host OUT completion
    input wire logic bm_out_done,
    input wire logic [1:0] bm_out_done_ep,
    input wire logic [6:0] bm_out_done_cnt,
    // interrupt
    output logic irq
);
    // ======================================================
    // endpoint arrays, entry zero is a null endpoint
    logic [7:0] oscnt_a [0:3];
    logic [7:0] osize_a [0:3];
    logic [7:0] cnf_a [0:3];
    logic [7:0] base_a [0:3];
    logic [7:0] pcnt_a [0:3];
    logic [7:0] rd_a [0:3];
    wire [3:0] stall_clr_v;
    wire [3:0] stall_set_v;
    wire [3:0] done_v;
    wire [3:0] done_p_v;
    wire [3:0] odone_v;
    assign oscnt_a[0] = 8'h00;
    assign osize_a[0] = 8'h00;
    assign cnf_a[0] = 8'h00;
    assign base_a[0] = 8'h00;
    assign pcnt_a[0] = 8'h00;
    assign rd_a[0] = 8'h00;
    assign stall_clr_v[0] = 1'b0;
    assign stall_set_v[0] = 1'b0;
    assign done_v[0] = 1'b0;
    assign done_p_v[0] = 1'b0;
    assign odone_v[0] = 1'b0;

    // ======================================================
    // axi write path
    logic aw_hold_q;
    logic w_hold_q;
    logic [31:0] waddr_q;
    logic [7:0] wdata_q;
    logic wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    wire [1:0] w_ep = waddr_q[6:5];
    wire [2:0] w_idx = waddr_q[4:2];
    wire w_low = (waddr_q[31:7] == 25'h0000000) &&
        (waddr_q[1:0] == 2'h0);
    wire w_ep_ok = w_low && (w_ep != 2'h0) && (w_idx <= `UEDF_IDX_PCNT);
    wire w_glb_ok = w_low && (w_ep == 2'h0) &&
        (w_idx <= `UEDF_ADDR_IRQ_MASK);
    wire wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    // narrow registers live in byte lane zero only
    wire sw_wr = wr_fire && wstrb_q;
    wire stat_wr = sw_wr && w_glb_ok && (w_idx == `UEDF_ADDR_IRQ_STAT);
    wire mask_wr = sw_wr && w_glb_ok && (w_idx == `UEDF_ADDR_IRQ_MASK);
    assign s_axi_awready = !aw_hold_q;
    assign s_axi_wready = !w_hold_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            waddr_q <= 32'h00000000;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_hold_q)
            begin
                aw_hold_q <= 1'b1;
                waddr_q <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_hold_q <= 1'b0;
            if (s_axi_wvalid && !w_hold_q)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wstrb_q <= s_axi_wstrb[0];
            end
            else if (wr_fire)
                w_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= `UEDF_RESP_OK;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= (w_ep_ok || w_glb_ok) ? `UEDF_RESP_OK :
                `UEDF_RESP_ERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    // ======================================================
    // axi read path
    logic rvalid_q;
    logic [7:0] rdata_q;
    logic [1:0] rresp_q;
    logic [3:1] irq_stat_q;
    logic [3:1] irq_mask_q;
    wire [1:0] r_ep = s_axi_araddr[6:5];
    wire [2:0] r_idx = s_axi_araddr[4:2];
    wire r_low = (s_axi_araddr[31:7] == 25'h0000000) &&
        (s_axi_araddr[1:0] == 2'h0);
    wire r_ep_ok = r_low && (r_ep != 2'h0) && (r_idx <= `UEDF_IDX_PCNT);
    wire r_glb_ok = r_low && (r_ep == 2'h0) &&
        (r_idx <= `UEDF_ADDR_IRQ_MASK);
    wire [7:0] r_glb = (r_idx == `UEDF_ADDR_IRQ_STAT) ?
        {4'h0, irq_stat_q, 1'b0} : {4'h0, irq_mask_q, 1'b0};
    wire [7:0] r_byte = r_ep_ok ? rd_a[r_ep] : (r_glb_ok ? r_glb : 8'h00);
    wire rd_fire = s_axi_arvalid && !rvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = {24'h000000, rdata_q};
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 8'h00;
            rresp_q <= `UEDF_RESP_OK;
        end
        else if (rd_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= r_byte;
            rresp_q <= (r_ep_ok || r_glb_ok) ? `UEDF_RESP_OK :
                `UEDF_RESP_ERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // ======================================================
    // host IN decision
    wire in_ok = bm_in_req && (bm_in_ep != 2'h0);
    wire [7:0] in_cnf = cnf_a[bm_in_ep];
    wire [7:0] in_pcnt = pcnt_a[bm_in_ep];
    wire [7:0] in_base_sel = base_a[bm_in_ep];
    wire in_second = in_cnf[`UEDF_DOUBLE_BUFFER_ENABLE] && in_cnf[`UEDF_TGL]; // RULE7
    // disabled endpoint is refused before anything else is looked at
    wire uedf_pkg::uedf_rsp_t in_rsp = !in_cnf[`UEDF_BME] ?
        uedf_pkg::rsp_off : // RULE10
        in_cnf[`UEDF_STALL] ? uedf_pkg::rsp_stall : // RULE6
        in_second ? uedf_pkg::rsp_second : // RULE7
        in_pcnt[`UEDF_NAK] ? uedf_pkg::rsp_nak : // RULE15
        uedf_pkg::rsp_primary;
    logic [1:0] in_ep_q;
    logic [1:0] chk_ep_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bm_in_valid_q <= 1'b0;
            bm_in_rsp_q <= uedf_pkg::rsp_off;
            bm_in_addr_q <= 11'h000;
            bm_in_cnt_q <= 7'h00;
            in_ep_q <= 2'h0;
            chk_ep_q <= 2'h0;
        end
        else
        begin
            bm_in_valid_q <= in_ok;
            in_ep_q <= bm_in_ep;
            chk_ep_q <= bm_in_done_ep;
            if (in_ok)
            begin
                bm_in_rsp_q <= in_rsp;
                bm_in_addr_q <= {in_base_sel, 3'h0}; // RULE11 RULE12
                bm_in_cnt_q <= in_pcnt[6:0]; // RULE14
            end
        end
    end

    // ======================================================
    // host OUT decision
    wire out_ok = bm_out_req && (bm_out_ep != 2'h0);
    wire [7:0] out_sc = oscnt_a[bm_out_ep];
    wire [7:0] out_sz = osize_a[bm_out_ep];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bm_out_valid_q <= 1'b0;
            bm_out_rsp_q <= uedf_pkg::rsp_nak;
            bm_out_size_q <= 7'h00;
        end
        else
        begin
            bm_out_valid_q <= out_ok;
            if (out_ok)
            begin
                bm_out_rsp_q <= out_sc[`UEDF_NAK] ? uedf_pkg::rsp_nak :
                    uedf_pkg::rsp_ack; // RULE2
                bm_out_size_q <= out_sz[6:0]; // RULE3
            end
        end
    end

    // ======================================================
    // endpoint slices
    for (genvar i = 1; i < 4; i++)
    begin : g_ep
        assign stall_clr_v[i] = in_ok && (bm_in_ep == 2'(i)) &&
            in_cnf[`UEDF_BME] && in_cnf[`UEDF_STALL]; // RULE6
        assign stall_set_v[i] = bm_stall_set &&
            (bm_stall_ep == 2'(i)); // RULE5
        assign done_v[i] = bm_in_done && (bm_in_done_ep == 2'(i));
        assign done_p_v[i] = done_v[i] && !bm_in_done_second; // RULE16
        assign odone_v[i] = bm_out_done && (bm_out_done_ep == 2'(i));
        uedf_ep u_ep (
            .aclk(aclk),
            .aresetn(aresetn),
            .wr_en(sw_wr && w_ep_ok && (w_ep == 2'(i))),
            .wr_idx(w_idx),
            .wr_data(wdata_q),
            .rd_idx(r_idx),
            .rd_data(rd_a[i]),
            .stall_clr(stall_clr_v[i]),
            .stall_set(stall_set_v[i]),
            .in_done(done_v[i]),
            .in_done_primary(done_p_v[i]),
            .out_done(odone_v[i]),
            .out_cnt(bm_out_done_cnt),
            .out_scnt_q(oscnt_a[i]),
            .out_size_q(osize_a[i]),
            .in_cnf_q(cnf_a[i]),
            .in_base_q(base_a[i]),
            .in_pcnt_q(pcnt_a[i])
        );
    end

    // ======================================================
    // completion interrupt
    wire [3:1] irq_set = {cnf_a[3][`UEDF_IE], cnf_a[2][`UEDF_IE],
        cnf_a[1][`UEDF_IE]} & done_v[3:1]; // RULE4 RULE16
    // a completion landing on the clearing write still counts
    wire [3:1] stat_d = irq_set |
        (irq_stat_q & ~(stat_wr ? wdata_q[3:1] : 3'h0));
    assign irq = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
        end
        else
        begin
            irq_stat_q <= stat_d;
            irq_mask_q <= mask_wr ? wdata_q[3:1] : irq_mask_q;
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire [7:0] done_cnf = cnf_a[bm_in_done_ep];
    wire done_tgl = done_cnf[`UEDF_TGL];
    wire done_ie = done_cnf[`UEDF_IE];

    property p_out_nak;
        out_ok && out_sc[`UEDF_NAK] |=>
            bm_out_valid_q && bm_out_rsp_q == uedf_pkg::rsp_nak;
    endproperty
    a_out_nak: assert property (p_out_nak) // RULE2
        else $error("full out buffer not refused");

    property p_out_cnt;
        bm_out_done && bm_out_done_ep == 2'h3 |=>
            oscnt_a[3] == {1'b1, $past(bm_out_done_cnt)};
    endproperty
    a_out_cnt: assert property (p_out_cnt) // RULE1
        else $error("out count or flag not stored");

    property p_out_size;
        out_ok |=> bm_out_size_q == $past(out_sz) && !osize_a[1][7];
    endproperty
    a_out_size: assert property (p_out_size) // RULE3
        else $error("out size wrong or reserved bit set");

    property p_in_off;
        in_ok && !in_cnf[`UEDF_BME] |=>
            bm_in_rsp_q == uedf_pkg::rsp_off;
    endproperty
    a_in_off: assert property (p_in_off) // RULE10
        else $error("disabled endpoint served");

    property p_in_stall;
        in_ok && in_rsp == uedf_pkg::rsp_stall && !sw_wr && !bm_stall_set |=>
            bm_in_rsp_q == uedf_pkg::rsp_stall &&
            !cnf_a[in_ep_q][`UEDF_STALL];
    endproperty
    a_in_stall: assert property (p_in_stall) // RULE6
        else $error("stall not answered or not cleared");

    property p_in_addr;
        in_ok && in_rsp == uedf_pkg::rsp_primary |=>
            bm_in_addr_q == {$past(in_base_sel), 3'h0} ##1
            $past(in_ok) || bm_in_addr_q == {$past(in_base_sel, 2), 3'h0};
    endproperty
    a_in_addr: assert property (p_in_addr) // RULE11
        else $error("start address wrong");

    property p_in_sel;
        in_ok && in_cnf[`UEDF_BME] && !in_cnf[`UEDF_STALL] |=>
            (bm_in_rsp_q == uedf_pkg::rsp_second) == $past(in_second);
    endproperty
    a_in_sel: assert property (p_in_sel) // RULE7
        else $error("buffer selection wrong");

    property p_in_nak;
        in_ok && in_rsp != uedf_pkg::rsp_off &&
            in_rsp != uedf_pkg::rsp_stall && !in_second |=>
            (bm_in_rsp_q == uedf_pkg::rsp_nak) ==
            $past(in_pcnt[`UEDF_NAK]);
    endproperty
    a_in_nak: assert property (p_in_nak) // RULE15
        else $error("empty in buffer not refused");

    property p_in_done;
        bm_in_done && bm_in_done_ep != 2'h0 && !bm_in_done_second |=>
            pcnt_a[chk_ep_q][`UEDF_NAK] &&
            cnf_a[chk_ep_q][`UEDF_TGL] != $past(done_tgl);
    endproperty
    a_in_done: assert property (p_in_done) // RULE16
        else $error("completion did not set flag and toggle");

    property p_irq;
        bm_in_done && bm_in_done_ep != 2'h0 |=>
            irq_stat_q[chk_ep_q] == ($past(done_ie) ||
            $past(irq_stat_q[bm_in_done_ep]) &&
            !$past(stat_wr && wdata_q[bm_in_done_ep]));
    endproperty
    a_irq: assert property (p_irq) // RULE4
        else $error("completion interrupt wrong");

    c_in_primary: cover property (in_ok &&
        in_rsp == uedf_pkg::rsp_primary ##[1:20] bm_in_done);
    c_in_stall: cover property (in_ok && in_rsp == uedf_pkg::rsp_stall);
    c_irq: cover property (irq ##[1:20] !irq);
endmodule : uedf_top

/* File: dv/uedf_bm_model.sv */
// buffer manager model: completes every packet the block lets it serve
// assumes answers come one cycle after each token, all on aclk
`timescale 1ns/1ns
module uedf_bm_model #(
    parameter logic [6:0] OUT_LEN = 7'h40
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // tokens and answers
    input wire logic bm_in_req,
    input wire logic [1:0] bm_in_ep,
    input wire logic bm_in_valid_q,
    input wire uedf_pkg::uedf_rsp_t bm_in_rsp_q,
    input wire logic bm_out_req,
    input wire logic [1:0] bm_out_ep,
    input wire logic bm_out_valid_q,
    input wire uedf_pkg::uedf_rsp_t bm_out_rsp_q,
    // completions
    output logic bm_in_done,
    output logic [1:0] bm_in_done_ep,
    output logic bm_in_done_second,
    output logic bm_out_done,
    output logic [1:0] bm_out_done_ep,
    output logic [6:0] bm_out_done_cnt
);
    // ======================================================
    // completion one cycle after a served answer
    logic [1:0] in_ep_q;
    logic [1:0] out_ep_q;
    logic in_ok;
    logic out_ok;
    assign in_ok = bm_in_valid_q && bm_in_rsp_q inside
        {uedf_pkg::rsp_primary, uedf_pkg::rsp_second};
    assign out_ok = bm_out_valid_q && bm_out_rsp_q == uedf_pkg::rsp_ack;
    initial
    begin
        {bm_in_done, bm_in_done_ep, bm_in_done_second} = 4'h0;
        {bm_out_done, bm_out_done_ep, bm_out_done_cnt} = 10'h000;
        {in_ep_q, out_ep_q} = 4'h0;
    end
    always @(posedge aclk)
    begin
        if (bm_in_req)
            in_ep_q <= bm_in_ep;
        if (bm_out_req)
            out_ep_q <= bm_out_ep;
        bm_in_done <= aresetn && in_ok;
        bm_in_done_ep <= in_ok ? in_ep_q : ~in_ep_q;
        bm_in_done_second <= bm_in_rsp_q == uedf_pkg::rsp_second;
        bm_out_done <= aresetn && out_ok;
        bm_out_done_ep <= out_ok ? out_ep_q : ~out_ep_q;
        // released count lines show junk, never the last value
        bm_out_done_cnt <= out_ok ? OUT_LEN : ~OUT_LEN;
    end
endmodule : uedf_bm_model

/* File: dv/uedf_top_bench.sv */
// self-checking bench for the descriptor block
// assumes bready and rready held high, full word strobes
`timescale 1ns/1ns
module uedf_top_bench;
    // ======================================================
    // signals
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic arvalid = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, in_ep = 2'h0, stall_ep = 2'h0, out_ep = 2'h0;
    logic in_req = 1'b0, stall_set = 1'b0, out_req = 1'b0;
    logic in_valid, in_done, in_second, out_valid, out_done;
    logic [1:0] in_done_ep, out_done_ep;
    logic [6:0] in_cnt, out_size, out_done_cnt;
    logic [10:0] in_addr;
    uedf_pkg::uedf_rsp_t in_rsp, out_rsp;
    int bad_count = 0, checks_done = 0;
    uedf_top i_uedf_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .bm_in_req(in_req), .bm_in_ep(in_ep),
        .bm_in_valid_q(in_valid), .bm_in_rsp_q(in_rsp),
        .bm_in_addr_q(in_addr), .bm_in_cnt_q(in_cnt), .bm_in_done(in_done),
        .bm_in_done_ep(in_done_ep), .bm_in_done_second(in_second),
        .bm_stall_set(stall_set), .bm_stall_ep(stall_ep),
        .bm_out_req(out_req), .bm_out_ep(out_ep),
        .bm_out_valid_q(out_valid), .bm_out_rsp_q(out_rsp),
        .bm_out_size_q(out_size), .bm_out_done(out_done),
        .bm_out_done_ep(out_done_ep), .bm_out_done_cnt(out_done_cnt),
        .irq(irq));
    uedf_bm_model i_uedf_bm_model (.aclk(aclk), .aresetn(aresetn),
        .bm_in_req(in_req), .bm_in_ep(in_ep), .bm_in_valid_q(in_valid),
        .bm_in_rsp_q(in_rsp), .bm_out_req(out_req), .bm_out_ep(out_ep),
        .bm_out_valid_q(out_valid), .bm_out_rsp_q(out_rsp),
        .bm_in_done(in_done), .bm_in_done_ep(in_done_ep),
        .bm_in_done_second(in_second), .bm_out_done(out_done),
        .bm_out_done_ep(out_done_ep), .bm_out_done_cnt(out_done_cnt));
    // ======================================================
    // shared tasks
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [7:0] d,
        input logic [1:0] er);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", bresp, er);
    endtask : wr
    task automatic rc(input logic [31:0] a, input logic [7:0] x,
        input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk("rresp", rresp, er);
        chk("rdata", rdata, {24'h0, x});
    endtask : rc
    // o selects the OUT token, else IN; answer is looked at while it stands
    task automatic bm(input bit o, input logic [1:0] e,
        input uedf_pkg::uedf_rsp_t x);
        if (o)
            out_req <= 1'b1;
        else
            in_req <= 1'b1;
        out_ep <= e;
        in_ep <= e;
        @(posedge aclk);
        {in_req, out_req} <= 2'b00;
        #1;
        chk("valid", o ? out_valid : in_valid, 1'b1);
        chk("rsp", o ? out_rsp : in_rsp, x);
        @(posedge aclk);
    endtask : bm
    // ======================================================
    // scenarios
    task automatic t_regs;
        rc(32'h28, 8'h00, 2'h0);
        rc(32'h30, 8'h80, 2'h0);
        chk("irq", irq, 1'b0);
        wr(32'h24, 8'hC0, 2'h0);
        rc(32'h24, 8'h40, 2'h0);
        wr(32'h48, 8'hBF, 2'h0);
        rc(32'h48, 8'hBC, 2'h0);
        wr(32'h34, 8'h11, 2'h2);
        rc(32'h34, 8'h00, 2'h2);
        $display("test regs done");
    endtask : t_regs
    task automatic t_in;
        wr(32'h2C, 8'hA5, 2'h0);
        wr(32'h30, 8'h40, 2'h0);
        wr(32'h28, 8'h84, 2'h0);
        wr(32'h04, 8'h02, 2'h0);
        bm(0, 2'h1, uedf_pkg::rsp_primary);
        chk("addr", in_addr, 11'h528);
        chk("cnt", in_cnt, 7'h40);
        repeat (3) @(posedge aclk);
        rc(32'h30, 8'hC0, 2'h0);
        rc(32'h28, 8'hA4, 2'h0);
        rc(32'h2C, 8'hA5, 2'h0);
        chk("irq", irq, 1'b1);
        bm(0, 2'h1, uedf_pkg::rsp_nak);
        wr(32'h04, 8'h00, 2'h0);
        chk("irq", irq, 1'b0);
        wr(32'h00, 8'h02, 2'h0);
        rc(32'h00, 8'h00, 2'h0);
        // interrupt enable off: completion must leave status clear
        wr(32'h28, 8'h80, 2'h0);
        wr(32'h30, 8'h10, 2'h0);
        bm(0, 2'h1, uedf_pkg::rsp_primary);
        repeat (3) @(posedge aclk);
        rc(32'h00, 8'h00, 2'h0);
        $display("test in done");
    endtask : t_in
    task automatic t_ctl;
        wr(32'h48, 8'h8C, 2'h0);
        bm(0, 2'h2, uedf_pkg::rsp_stall);
        rc(32'h48, 8'h84, 2'h0);
        stall_ep <= 2'h2;
        stall_set <= 1'b1;
        @(posedge aclk);
        stall_set <= 1'b0;
        rc(32'h48, 8'h8C, 2'h0);
        wr(32'h48, 8'hB0, 2'h0);
        bm(0, 2'h2, uedf_pkg::rsp_second);
        repeat (2) @(posedge aclk);
        rc(32'h48, 8'h90, 2'h0);
        wr(32'h48, 8'h30, 2'h0);
        bm(0, 2'h2, uedf_pkg::rsp_off);
        $display("test control done");
    endtask : t_ctl
    task automatic t_out;
        wr(32'h64, 8'h40, 2'h0);
        bm(1, 2'h3, uedf_pkg::rsp_ack);
        chk("size", out_size, 7'h40);
        repeat (3) @(posedge aclk);
        rc(32'h60, 8'hC0, 2'h0);
        bm(1, 2'h3, uedf_pkg::rsp_nak);
        $display("test out done");
    endtask : t_out
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // ======================================================
    // clock, watchdog, main sequence
    initial
    begin
        forever #25 aclk = ~aclk;
    end
    initial
    begin
        // whole run is about a hundred cycles
        #200000;
        bad_count++;
        close_out();
    end
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_in();
        t_ctl();
        t_out();
        close_out();
    end
endmodule : uedf_top_bench
